// *** src/drg_pkg.sv ***
// Package: shared constants and types for the DRAM access and refresh glue
package drg_pkg;
	// Optional wait states added when the wait request is low
	localparam int unsigned OPT_WAIT_STATES = 1;
	// Idle (inactive) level of active-low registered outputs after reset
	localparam logic        RST_HIGH        = 1'b1;
	// Mode pin inactive value (normal access mode)
	localparam logic        MODE_NORMAL     = 1'b1;
	// Mode pin active value (forced refresh)
	localparam logic        MODE_FORCED     = 1'b0;
	// Registered delay-chain state kept by the device end
	typedef struct packed {
		logic mode_n;
		logic dly_a_n;
		logic dly_b_n;
		logic dly_c_n;
	} drg_chain_t;
	// Reset value of the delay chain: all inactive
	localparam drg_chain_t CHAIN_RESET = '{mode_n: 1'b1, dly_a_n: 1'b1, dly_b_n: 1'b1, dly_c_n: 1'b1};
endpackage

// *** src/drg_link_if.sv ***
// Interface: signals between the bus/controller side and the glue device
`timescale 1ns/100ps
`default_nettype none
interface drg_link_if;
	logic addr_strobe_n;
	logic chip_select_n;
	logic read_not_write;
	logic refresh_request_in;
	logic any_byte_strobe;
	logic wait_req_n;
	logic hidden_refresh_disable_n;
	logic out_enable_n;
	logic row_strobe_request_n;
	logic transfer_ack_n;
	logic cycle_done_n;
	logic access_during_refresh_n;
	logic controller_mode_select;
	logic delay_stage_a_n;
	logic delay_stage_b_n;
	logic delay_stage_c_n;
	// Device end: the glue logic
	modport device (
		input  addr_strobe_n, chip_select_n, read_not_write, refresh_request_in,
		input  any_byte_strobe, wait_req_n, hidden_refresh_disable_n, out_enable_n,
		output row_strobe_request_n, transfer_ack_n, cycle_done_n, access_during_refresh_n,
		output controller_mode_select, delay_stage_a_n, delay_stage_b_n, delay_stage_c_n
	);
	// System end: the bus master and controller side
	modport system (
		output addr_strobe_n, chip_select_n, read_not_write, refresh_request_in,
		output any_byte_strobe, wait_req_n, hidden_refresh_disable_n, out_enable_n,
		input  row_strobe_request_n, transfer_ack_n, cycle_done_n, access_during_refresh_n,
		input  controller_mode_select, delay_stage_a_n, delay_stage_b_n, delay_stage_c_n
	);
endinterface
`default_nettype wire

// *** src/drg_system_end.sv ***
// System end: passes user bus requests straight through to the glue inputs
`timescale 1ns/100ps
`default_nettype none
module drg_system_end (
	input  wire logic      i_clock,
	input  wire logic      i_rstn,
	input  wire logic      i_addr_strobe_n,
	input  wire logic      i_chip_select_n,
	input  wire logic      i_read_not_write,
	input  wire logic      i_upper_byte_strobe_n,
	input  wire logic      i_lower_byte_strobe_n,
	input  wire logic      i_refresh_request_in,
	input  wire logic      i_wait_req_n,
	input  wire logic      i_hidden_refresh_disable_n,
	input  wire logic      i_col_strobe_n,
	drg_link_if.system     link,
	output logic           o_transfer_ack_n,
	output logic           o_row_strobe_request_n,
	output logic           o_controller_mode_select,
	output logic           o_upper_col_strobe_n,
	output logic           o_lower_col_strobe_n
);
	import drg_pkg::*;

	logic ubs_q;
	logic lbs_q;

	// Bus side straight through; link is same-clock logic
	assign link.addr_strobe_n            = i_addr_strobe_n;
	assign link.chip_select_n            = i_chip_select_n;
	assign link.read_not_write           = i_read_not_write;
	assign link.refresh_request_in       = i_refresh_request_in;
	assign link.wait_req_n               = i_wait_req_n;
	assign link.hidden_refresh_disable_n = i_hidden_refresh_disable_n;
	// Combined strobe low when either byte strobe is low
	assign link.any_byte_strobe          = i_upper_byte_strobe_n & i_lower_byte_strobe_n;
	// Outputs of the glue stay enabled
	assign link.out_enable_n             = 1'b0;

	// Byte lane split of the column strobe, kept per lane
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			ubs_q <= RST_HIGH;
			lbs_q <= RST_HIGH;
		end else begin
			ubs_q <= i_upper_byte_strobe_n;
			lbs_q <= i_lower_byte_strobe_n;
		end
	end

	// Registered copies of glue outputs and lane column strobes for the user side
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			o_transfer_ack_n         <= RST_HIGH;
			o_row_strobe_request_n   <= RST_HIGH;
			o_controller_mode_select <= MODE_NORMAL;
			o_upper_col_strobe_n     <= RST_HIGH;
			o_lower_col_strobe_n     <= RST_HIGH;
		end else begin
			o_transfer_ack_n         <= link.transfer_ack_n;
			o_row_strobe_request_n   <= link.row_strobe_request_n;
			o_controller_mode_select <= link.controller_mode_select;
			// Page-mode column strobes per byte lane
			o_upper_col_strobe_n     <= i_col_strobe_n | ubs_q;
			o_lower_col_strobe_n     <= i_col_strobe_n | lbs_q;
		end
	end
endmodule
`default_nettype wire

// *** src/drg_device_end.sv ***
// Device end: access decode, refresh arbitration and acknowledge timing
`timescale 1ns/100ps
`default_nettype none
module drg_device_end (
	input  wire logic      i_clock,
	input  wire logic      i_rstn,
	drg_link_if.device     link,
	output logic           o_access_active,
	output logic           o_refresh_forced
);
	import drg_pkg::*;

	// Active-high views of the inputs, plus the low clock phase
	logic as_a;
	logic cs_a;
	logic rd_a;
	logic refresh_request_in_a;
	logic ds_a;
	logic wait_a;
	logic dh_a;
	logic clk_lo;
	// Registered active-high state and its next values
	logic mode_q;
	logic d2_q;
	logic d3_q;
	logic d4_q;
	logic cyc_q;
	logic incy_q;
	logic ack_q;
	logic ras_q;
	logic ras_d;
	logic cyc_d;
	logic incy_d;
	logic ack_d;
	logic mode_d;
	logic d2_d;
	logic d4_d;

	assign as_a   = ~link.addr_strobe_n;
	assign cs_a   = ~link.chip_select_n;
	// Direction decides read versus write
	assign rd_a   = link.read_not_write;
	assign refresh_request_in_a = link.refresh_request_in;
	assign ds_a   = ~link.any_byte_strobe;
	assign wait_a = ~link.wait_req_n;
	assign dh_a   = ~link.hidden_refresh_disable_n;
	// Low clock phase is modelled by the delay-stage c marking state three
	assign clk_lo = d4_q;

	// Row strobe request terms
	always_comb begin
		ras_d = 1'b0;
		// Selected access starts when select and strobe true
		if (cs_a && !incy_q && as_a && !mode_q && d4_q && !cyc_q && clk_lo)
			ras_d = 1'b1;
		// Hidden refresh on foreign access unless disabled
		if (!cs_a && !incy_q && as_a && !mode_q && d2_q && !cyc_q && !dh_a)
			ras_d = 1'b1;
		// Pending access proceeds once refresh is over
		if (cs_a && incy_q && as_a && !mode_q && d4_q && !cyc_q && clk_lo)
			ras_d = 1'b1;
		// Hold while the cycle lasts
		if ((cs_a && ras_q && !mode_q && as_a) || (ras_q && !mode_q && d2_q))
			ras_d = 1'b1;
	end

	// Cycle done terms
	always_comb begin
		cyc_d = (!mode_q && d2_q && d3_q && !d4_q)
			|| (cyc_q && as_a)
			|| (!cs_a && as_a && !mode_q && !d2_q && !d3_q && !d4_q);
	end

	// Access-during-refresh set and hold
	always_comb begin
		incy_d = (mode_q && as_a) || (incy_q && d4_q && as_a);
	end

	// Acknowledge: zero or one wait state by wait request
	always_comb begin
		ack_d = 1'b0;
		if (cs_a) begin
			// Writes: gated by delay stage a when waiting; never during refresh
			if (as_a && !rd_a && !mode_q && (!wait_a || d2_q))
				ack_d = 1'b1;
			// Reads use combined byte strobe for test-and-set
			if (ds_a && rd_a && !mode_q && (!wait_a || d2_q))
				ack_d = 1'b1;
			// Continuation terms, including read-modify-write
			if ((ack_q && d2_q && !mode_q) || (ack_q && as_a && ras_q && !mode_q && !cyc_q)
				|| (ack_q && as_a && !rd_a && !mode_q))
				ack_d = 1'b1;
		end
	end

	// Forced refresh mode
	// The request is active high; starting only with no row request pending, and with no finished
	// cycle pending except in a foreign access, keeps a refresh from cutting into a DRAM access under way
	always_comb begin
		mode_d = (refresh_request_in_a && !as_a && !cyc_q && !ras_q)
			// Long access to another device: refresh in its quiet tail
			|| (!cs_a && refresh_request_in_a && as_a && cyc_q && !d2_q && !d3_q && !ras_q)
			|| (mode_q && !d3_q) || (mode_q && !d4_q);
	end

	// Delay chain next values
	always_comb begin
		d2_d = (mode_q && !d4_q)
			|| (!incy_q && as_a && !cyc_q && !mode_q && !d3_q && d4_q)
			|| (cs_a && incy_q && as_a && !cyc_q && !mode_q && !d3_q && d4_q)
			|| (!mode_q && d2_q && !d3_q)
			// Second stage pass for a wait state when the wait request is low
			|| (cs_a && wait_a && as_a && !mode_q && d2_q && d3_q && !d4_q)
			|| (cs_a && as_a && !rd_a && cyc_q && !mode_q && !d2_q && !d3_q && !d4_q);
		d4_d = d3_q || (!as_a && !mode_q)
			|| (!cs_a && refresh_request_in_a && as_a && cyc_q && !d2_q && !d3_q && !ras_q && !mode_q);
	end

	// Registered state on rising clock; reset for simulation only
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			mode_q <= ~CHAIN_RESET.mode_n;
			d2_q   <= ~CHAIN_RESET.dly_a_n;
			d3_q   <= ~CHAIN_RESET.dly_b_n;
			d4_q   <= ~CHAIN_RESET.dly_c_n;
		end else begin
			mode_q <= mode_d;
			d2_q   <= d2_d;
			d3_q   <= d2_q && !d4_q;
			d4_q   <= d4_d;
		end
	end

	// Cycle done flag
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			cyc_q <= ~RST_HIGH;
		end else begin
			cyc_q <= cyc_d;
		end
	end

	// Access-during-refresh flag
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			incy_q <= ~RST_HIGH;
		end else begin
			incy_q <= incy_d;
		end
	end

	// Acknowledge held off during waits
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			ack_q <= ~RST_HIGH;
		end else begin
			ack_q <= ack_d;
		end
	end

	// Row strobe request
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			ras_q <= ~RST_HIGH;
		end else begin
			ras_q <= ras_d;
		end
	end

	// Active-low pins toward the link; output enable is held low by the system
	assign link.row_strobe_request_n    = ~ras_q;
	assign link.transfer_ack_n          = ~ack_q;
	assign link.cycle_done_n            = ~cyc_q;
	assign link.access_during_refresh_n = ~incy_q;
	assign link.controller_mode_select  = mode_q ? MODE_FORCED : MODE_NORMAL;
	assign link.delay_stage_a_n         = ~d2_q;
	assign link.delay_stage_b_n         = ~d3_q;
	assign link.delay_stage_c_n         = ~d4_q;

	// User-side status copies
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			o_access_active  <= ~RST_HIGH;
			o_refresh_forced <= ~RST_HIGH;
		end else begin
			o_access_active  <= ras_q;
			o_refresh_forced <= mode_q;
		end
	end
endmodule
`default_nettype wire

// *** bench/drg_sva.sv ***
// Checker: link timing relations between the two glue ends
`timescale 1ns/100ps
`default_nettype none
module drg_sva (
	input wire logic i_clock,
	input wire logic i_rstn,
	input wire logic addr_strobe_n,
	input wire logic chip_select_n,
	input wire logic refresh_request_in,
	input wire logic wait_req_n,
	input wire logic hidden_refresh_disable_n,
	input wire logic row_strobe_request_n,
	input wire logic transfer_ack_n,
	input wire logic cycle_done_n,
	input wire logic access_during_refresh_n,
	input wire logic controller_mode_select
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rstn);
	// Selected cycle opening while no refresh is running
	sequence s_sel_start;
		$fell(addr_strobe_n) && !chip_select_n && controller_mode_select && access_during_refresh_n;
	endsequence
	property p_row_req; s_sel_start |-> ##[1:4] !row_strobe_request_n; endproperty
	a_row_req: assert property (p_row_req) else $error("row request missing");
	property p_ack_wait; s_sel_start ##0 !wait_req_n |-> transfer_ack_n [*2]; endproperty
	a_ack_wait: assert property (p_ack_wait) else $error("wait state skipped");
	property p_ack_end; $rose(addr_strobe_n) |-> ##[0:2] transfer_ack_n; endproperty
	a_ack_end: assert property (p_ack_end) else $error("ack kept after strobe");
	// Ack must stay off while a held access waits on forced refresh
	property p_ack_hold; !access_during_refresh_n && !controller_mode_select |-> transfer_ack_n; endproperty
	a_ack_hold: assert property (p_ack_hold) else $error("ack during refresh");
	property p_dh_block; (!hidden_refresh_disable_n && chip_select_n) [*3] |-> row_strobe_request_n; endproperty
	a_dh_block: assert property (p_dh_block) else $error("row request unselected");
	property p_done_set; s_sel_start |-> ##[1:8] (!cycle_done_n || addr_strobe_n); endproperty
	a_done_set: assert property (p_done_set) else $error("cycle done never set");
	property p_done_clr; addr_strobe_n [*3] |-> cycle_done_n; endproperty
	a_done_clr: assert property (p_done_clr) else $error("cycle done stuck low");
	// Forced refresh only on request and never over a running row request
	property p_mode_cause;
		$fell(controller_mode_select) |-> $past(refresh_request_in) && $past(row_strobe_request_n);
	endproperty
	a_mode_cause: assert property (p_mode_cause) else $error("mode without request");
	property p_adr_cause;
		$fell(access_during_refresh_n) |-> !$past(controller_mode_select) && !$past(addr_strobe_n);
	endproperty
	a_adr_cause: assert property (p_adr_cause) else $error("refresh flag without cause");
endmodule
`default_nettype wire

// *** bench/testbench.sv ***
// Testbench: both glue ends joined over the link, driven from the bus side
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic i_clock, i_rstn, i_addr_strobe_n, i_chip_select_n, i_read_not_write;
	logic i_upper_byte_strobe_n, i_lower_byte_strobe_n, i_refresh_request_in, i_wait_req_n;
	logic i_hidden_refresh_disable_n, i_col_strobe_n, o_transfer_ack_n, o_row_strobe_request_n;
	logic o_controller_mode_select, o_upper_col_strobe_n, o_lower_col_strobe_n, row_seen;
	logic o_access_active, o_refresh_forced, lane_ok, act_seen;
	int   lat, r0, w0, n, miscompares, comparisons;
	drg_link_if link ();
	drg_system_end i_drg_system_end (.i_clock, .i_rstn, .i_addr_strobe_n, .i_chip_select_n, .i_read_not_write,
		.i_upper_byte_strobe_n, .i_lower_byte_strobe_n, .i_refresh_request_in, .i_wait_req_n,
		.i_hidden_refresh_disable_n, .i_col_strobe_n, .link, .o_transfer_ack_n, .o_row_strobe_request_n,
		.o_controller_mode_select, .o_upper_col_strobe_n, .o_lower_col_strobe_n);
	drg_device_end i_drg_device_end (.i_clock, .i_rstn, .link, .o_access_active, .o_refresh_forced);
	drg_sva i_drg_sva (.i_clock, .i_rstn, .addr_strobe_n(link.addr_strobe_n), .chip_select_n(link.chip_select_n),
		.refresh_request_in(link.refresh_request_in), .wait_req_n(link.wait_req_n),
		.hidden_refresh_disable_n(link.hidden_refresh_disable_n), .transfer_ack_n(link.transfer_ack_n),
		.row_strobe_request_n(link.row_strobe_request_n), .cycle_done_n(link.cycle_done_n),
		.access_during_refresh_n(link.access_during_refresh_n),
		.controller_mode_select(link.controller_mode_select));
	task automatic report_and_stop();
		$display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic check(input logic seen, input logic exp, input string what);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %0t ns: %s", $time, what);
		end
	endtask
	// Strobe held until ack or 12 clocks; column strobe mimics the controller
	task automatic bus_cycle(input logic cs_n, input logic rd, input logic wt_n);
		@(negedge i_clock);
		i_chip_select_n = cs_n;
		i_read_not_write = rd;
		i_wait_req_n = wt_n;
		i_lower_byte_strobe_n = 1'b0;
		i_addr_strobe_n = 1'b0;
		lat = 0;
		row_seen = 1'b0;
		while (lat < 12 && o_transfer_ack_n !== 1'b0) begin
			@(negedge i_clock);
			lat++;
			row_seen |= ~o_row_strobe_request_n;
			i_col_strobe_n = o_row_strobe_request_n;
		end
		@(negedge i_clock);
		// Lane strobes and the status copy, sampled while the access still stands
		lane_ok = (o_lower_col_strobe_n === 1'b0) && (o_upper_col_strobe_n === 1'b1);
		act_seen = o_access_active;
		{i_addr_strobe_n, i_chip_select_n, i_lower_byte_strobe_n, i_col_strobe_n} = 4'hf;
		repeat (4) @(negedge i_clock);
		$display("test done: cs_n=%0b rd=%0b wait_n=%0b lat=%0d", cs_n, rd, wt_n, lat);
	endtask
	initial begin
		i_clock = 1'b0;
		forever #5 i_clock = ~i_clock;
	end
	// Watchdog: the sequence needs about 100 clocks
	initial begin
		repeat (2000) @(posedge i_clock);
		miscompares++;
		report_and_stop();
	end
	initial begin
		{i_addr_strobe_n, i_chip_select_n, i_upper_byte_strobe_n, i_lower_byte_strobe_n, i_col_strobe_n} = 5'h1f;
		{i_read_not_write, i_refresh_request_in, i_wait_req_n, i_hidden_refresh_disable_n} = 4'hb;
		miscompares = 0;
		comparisons = 0;
		i_rstn = 1'b0;
		repeat (2) @(posedge i_clock);
		@(negedge i_clock);
		i_rstn = 1'b1;
		bus_cycle(1'b0, 1'b1, 1'b1);
		r0 = lat;
		check(row_seen, 1'b1, "no row request on read");
		check(lat < 12, 1'b1, "no ack on read");
		check(lane_ok, 1'b1, "lower lane column strobe");
		check(act_seen, 1'b1, "access status copy");
		bus_cycle(1'b0, 1'b1, 1'b0);
		check(lat == r0 + 1, 1'b1, "read wait count");
		bus_cycle(1'b0, 1'b0, 1'b1);
		w0 = lat;
		check(row_seen, 1'b1, "no row request on write");
		check(lane_ok, 1'b1, "lower lane strobe on write");
		bus_cycle(1'b0, 1'b0, 1'b0);
		check(lat == w0 + 1, 1'b1, "write wait count");
		bus_cycle(1'b1, 1'b1, 1'b0);
		check(row_seen, 1'b1, "no hidden refresh");
		i_hidden_refresh_disable_n = 1'b0;
		bus_cycle(1'b1, 1'b1, 1'b1);
		check(row_seen, 1'b0, "row request while disabled");
		i_hidden_refresh_disable_n = 1'b1;
		// Refresh request raised in the idle tail of a long foreign access
		fork
			bus_cycle(1'b1, 1'b1, 1'b1);
			begin
				repeat (6) @(negedge i_clock);
				i_refresh_request_in = 1'b1;
				for (n = 0; n < 6 && o_controller_mode_select !== 1'b0; n++) begin
					@(negedge i_clock);
				end
				check(o_controller_mode_select, 1'b0, "no refresh in foreign access");
				i_refresh_request_in = 1'b0;
			end
		join
		// Forced refresh from idle, then a selected access lands inside it
		i_refresh_request_in = 1'b1;
		for (n = 0; n < 10 && o_controller_mode_select !== 1'b0; n++) begin
			@(negedge i_clock);
		end
		check(o_controller_mode_select, 1'b0, "forced refresh missing");
		check(o_refresh_forced, 1'b1, "refresh status copy");
		i_refresh_request_in = 1'b0;
		bus_cycle(1'b0, 1'b1, 1'b1);
		check(lat > r0 && lat < 12, 1'b1, "access in refresh not held");
		report_and_stop();
	end
endmodule
`default_nettype wire
